// ### rtl/usbft_ctrl.sv
// transceiver control register, line status and endpoint address decode
`timescale 1ns/10ps
module usbft_ctrl (
	input  wire logic       CLK_I,          // usb clock, 25 MHz
	input  wire logic       RESETN_I,       // async reset, active low
	input  wire logic [7:0] SFR_ADDR_I,     // register address
	input  wire logic       SFR_WR_I,       // write strobe
	input  wire logic       SFR_RD_I,       // read strobe
	input  wire logic [7:0] SFR_WDATA_I,    // write data
	output logic [7:0]      SFR_RDATA_O,    // read data, one cycle after strobe
	input  wire logic       VBUS_I,         // bus power detect pin
	input  wire logic       DP_I,           // D+ pin level
	output logic            DP_O,           // D+ drive value
	output logic            DP_OE_N_O,      // D+ enable, low drives
	input  wire logic       DM_I,           // D- pin level
	output logic            DM_O,           // D- drive value
	output logic            DM_OE_N_O,      // D- enable, low drives
	output logic            DP_PULLUP_O,    // pull-up on D+
	output logic            DM_PULLUP_O,    // pull-up on D-
	output logic            FULL_SPEED_O,   // 1 full speed, 0 low speed
	output logic            XCVR_EN_O,      // transceiver enabled
	input  wire logic       TOK_VALID_I,    // token endpoint address offered
	output logic            TOK_READY_O,    // token accepted
	input  wire logic [7:0] TOK_ADDR_I,     // protocol endpoint address
	input  wire logic       TOK_IN_I,       // direction, used for endpoint zero
	output logic            PIPE_VALID_O,   // decoded pipe available
	input  wire logic       PIPE_READY_I,   // consumer takes pipe
	output logic            PIPE_HIT_O,     // address maps to a pipe
	output logic [2:0]      PIPE_SEL_O,     // pipe index {ep[1:0], in}
	output logic [9:0]      PIPE_BASE_O     // pipe base in buffer memory
);
	logic       rst_meta_ff;
	logic       rst_sync_ff;
	logic       rst_n;
	logic [2:0] pin_meta_ff;
	logic [2:0] pin_sync_ff;
	logic [4:0] ctrl_ff;
	logic [7:0] rdata_ff;
	logic       dp_ff;
	logic       dm_ff;
	logic       dp_oe_n_ff;
	logic       dm_oe_n_ff;
	logic       sel_wr;
	logic       sel_rd;
	logic       vbus;
	logic       differential_line_state;
	logic       dplus_level;
	logic       dminus_level;
	logic [7:0] status;
	logic       b_valid;
	logic [8:0] b_data;
	logic [3:0] pipe_dec;
	usbft_pkg::usbft_test_t test_mode;

	// one address decoder so read and write can never disagree on the match
	function automatic logic ctrl_addr_match(input logic [7:0] addr);
		return addr == usbft_pkg::XCVR_CTRL_ADDR;
	endfunction : ctrl_addr_match

	// pull-up sits on the line of the chosen speed and never without bus power
	function automatic logic pullup_on(
		input logic enable,   // register bit
		input logic power,    // synchronised bus power
		input logic on_dplus, // asking for the D+ resistor
		input logic full      // speed bit
	);
		return enable && power && (on_dplus == full);
	endfunction : pullup_on

	// endpoint zero answers only at 0x00 and takes its direction from the token;
	// anything off the table reports no hit and pipe zero, never a half decode
	function automatic logic [3:0] pipe_decode(input logic [8:0] tok);
		logic [6:0] ep_num;
		logic       is_in;
		ep_num = tok[6:0];
		is_in  = (tok[7:0] & usbft_pkg::EP_IN_FLAG) != 8'h00;
		if (tok[7:0] == 8'h00) begin
			return {1'b1, 2'h0, tok[8]}; // R03
		end
		if ((ep_num != 7'h00) && (ep_num <= usbft_pkg::EP_MAX_NUM)) begin
			return {1'b1, ep_num[1:0], is_in}; // R04
		end
		return 4'h0;
	endfunction : pipe_decode

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	assign rst_n = rst_sync_ff;

	// pins come from outside the clock domain
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_ff <= 3'h0;
			pin_sync_ff <= 3'h0;
		end else begin
			pin_meta_ff <= {VBUS_I, DP_I, DM_I};
			pin_sync_ff <= pin_meta_ff;
		end
	end
	assign vbus = pin_sync_ff[2];

	// strobes qualified by the one mapped address
	assign sel_wr = SFR_WR_I && ctrl_addr_match(SFR_ADDR_I);
	assign sel_rd = SFR_RD_I && ctrl_addr_match(SFR_ADDR_I);

	// writable upper five bits; status bits ignore writes
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= usbft_pkg::XCVR_CTRL_RESET; // R05
		end else if (sel_wr) begin
			ctrl_ff <= SFR_WDATA_I[usbft_pkg::PULLUP_BIT:usbft_pkg::TEST_LO_BIT]; // R05 R09
		end
	end

	// register bits go straight out; speed moves the pull-up live
	assign XCVR_EN_O    = ctrl_ff[usbft_pkg::XCVR_EN_BIT - 3];
	assign FULL_SPEED_O = ctrl_ff[usbft_pkg::SPEED_BIT - 3]; // R06 R07
	assign test_mode    = usbft_pkg::usbft_test_t'(ctrl_ff[1:0]); // R09

	// pull-up needs enable and bus power; speed picks the line
	assign DP_PULLUP_O = pullup_on(ctrl_ff[usbft_pkg::PULLUP_BIT - 3], vbus, 1'b1, FULL_SPEED_O); // R06 R08 R11
	assign DM_PULLUP_O = pullup_on(ctrl_ff[usbft_pkg::PULLUP_BIT - 3], vbus, 1'b0, FULL_SPEED_O); // R07 R08 R11

	// differential receiver only meaningful with the transceiver on
	assign dplus_level             = pin_sync_ff[1]; // R13
	assign dminus_level            = pin_sync_ff[0]; // R13
	assign differential_line_state = XCVR_EN_O && dplus_level && !dminus_level; // R12
	assign status                  = {ctrl_ff, differential_line_state, dplus_level, dminus_level}; // R09 R12 R13

	// read data registered; other addresses read zero
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 8'h00;
		end else if (SFR_RD_I) begin
			rdata_ff <= sel_rd ? status : 8'h00; // R13
		end
	end
	assign SFR_RDATA_O = rdata_ff;

	// forced line states for test; normal mode leaves pins to the engine
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			dp_ff      <= 1'b0;
			dm_ff      <= 1'b0;
			dp_oe_n_ff <= 1'b1;
			dm_oe_n_ff <= 1'b1;
		end else begin
			dp_oe_n_ff <= 1'b1;
			dm_oe_n_ff <= 1'b1;
			dp_ff      <= 1'b0;
			dm_ff      <= 1'b0;
			if (XCVR_EN_O) begin
				case (test_mode) // R09
					usbft_pkg::USBFT_TEST_FORCE_J: begin
						{dp_ff, dm_ff}           <= 2'h2;
						{dp_oe_n_ff, dm_oe_n_ff} <= 2'h0;
					end
					usbft_pkg::USBFT_TEST_FORCE_K: begin
						{dp_ff, dm_ff}           <= 2'h1;
						{dp_oe_n_ff, dm_oe_n_ff} <= 2'h0;
					end
					usbft_pkg::USBFT_TEST_FORCE_SE0: begin
						{dp_ff, dm_ff}           <= 2'h0;
						{dp_oe_n_ff, dm_oe_n_ff} <= 2'h0;
					end
					default: begin
						{dp_oe_n_ff, dm_oe_n_ff} <= 2'h3;
					end
				endcase
			end
		end
	end
	// pins straight from flops so a forced state never glitches
	assign DP_O      = dp_ff;
	assign DM_O      = dm_ff;
	assign DP_OE_N_O = dp_oe_n_ff;
	assign DM_OE_N_O = dm_oe_n_ff;

	// tokens buffered so a stalled consumer drops nothing
	usbft_skid #(
		.W (9)
	) u_tok_buf (
		.clk       (CLK_I),
		.rst_n     (rst_n),
		.in_valid  (TOK_VALID_I),
		.in_ready  (TOK_READY_O),
		.in_data   ({TOK_IN_I, TOK_ADDR_I}),
		.out_valid (b_valid),
		.out_ready (PIPE_READY_I),
		.out_data  (b_data)
	);

	// function side only: tokens come from the host, never issued here
	assign PIPE_VALID_O = b_valid; // R01

	// endpoint zero answers 0x00 both ways; 1..3 carry direction in bit 7
	assign pipe_dec   = pipe_decode(b_data); // R03 R04
	assign PIPE_HIT_O = pipe_dec[3]; // R03 R04
	assign PIPE_SEL_O = pipe_dec[2:0]; // R03 R04

	// each of the eight pipes owns an equal slice of the 1 kB buffer
	assign PIPE_BASE_O = 10'(PIPE_SEL_O * usbft_pkg::PIPE_BYTES); // R02
endmodule : usbft_ctrl

// ### common/usbft_pkg.sv
// constants for the usb function transceiver control block
// Contract
// R01: peripheral function only, never bus host
// R02: one kilobyte shared endpoint buffer memory
// R03: eight pipes; endpoint zero bidirectional at 0x00
// R04: pipes one-three: IN 0x81-0x83, OUT 0x01-0x03
// R05: one register: enable, pull-up, speed
// R06: speed one: full speed, pull-up D+
// R07: speed zero: low speed, pull-up D-
// R08: pull-up connects only with bus power
// R09: low five bits: test mode, line status
// R10: firmware runs usb clock before enabling
// R11: pull-up enable clear keeps device detached
// R12: differential state readable while transceiver enabled
// R13: D+ and D- pin levels readable
package usbft_pkg;
	localparam logic [7:0] XCVR_CTRL_ADDR  = 8'hD7;
	localparam logic [4:0] XCVR_CTRL_RESET = 5'h00;
	localparam int         PULLUP_BIT      = 7;
	localparam int         XCVR_EN_BIT     = 6;
	localparam int         SPEED_BIT       = 5;
	localparam int         TEST_HI_BIT     = 4;
	localparam int         TEST_LO_BIT     = 3;
	localparam int         DIFF_BIT        = 2;
	localparam int         DPLUS_BIT       = 1;
	localparam int         DMINUS_BIT      = 0;
	localparam int         PIPE_COUNT      = 8;
	localparam int         BUF_BYTES       = 1024;
	localparam int         PIPE_BYTES      = BUF_BYTES / PIPE_COUNT;
	localparam logic [7:0] EP_IN_FLAG      = 8'h80;
	localparam logic [6:0] EP_MAX_NUM      = 7'h03;
	// transceiver test modes
	typedef enum logic [1:0] {
		USBFT_TEST_NORMAL,
		USBFT_TEST_FORCE_J,
		USBFT_TEST_FORCE_K,
		USBFT_TEST_FORCE_SE0
	} usbft_test_t;
endpackage : usbft_pkg

// ### rtl/usbft_skid.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module usbft_skid #(
	parameter int W = 9
) (
	input  wire logic         clk,     // block clock
	input  wire logic         rst_n,   // synchronised reset, active low
	input  wire logic         in_valid, // word offered
	output logic              in_ready, // room for a word
	input  wire logic [W-1:0] in_data,  // word in
	output logic              out_valid, // word available
	input  wire logic         out_ready, // consumer takes word
	output logic [W-1:0]      out_data   // oldest word
);
	logic [W-1:0] mem_ff [2];
	logic         wptr_ff;
	logic         rptr_ff;
	logic [1:0]   count_ff;
	logic         push;
	logic         pop;

	// honest full and empty from the fill count
	assign in_ready  = (count_ff != 2'h2);
	assign out_valid = (count_ff != 2'h0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_ff[rptr_ff];

	// storage has no reset, only the pointers matter
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wptr_ff] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_ff  <= 1'b0;
			rptr_ff  <= 1'b0;
			count_ff <= 2'h0;
		end else begin
			if (push) begin
				wptr_ff <= ~wptr_ff;
			end
			if (pop) begin
				rptr_ff <= ~rptr_ff;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 2'h1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 2'h1;
			end
		end
	end
endmodule : usbft_skid

// ### tb/usbft_checker.sv
// port assertions for the transceiver control block
`timescale 1ns/10ps
module usbft_checker (
	input wire logic       CLK_I,        // clock
	input wire logic       RESETN_I,     // reset, low
	input wire logic [7:0] SFR_ADDR_I,   // address
	input wire logic       SFR_WR_I,     // write
	input wire logic       SFR_RD_I,     // read
	input wire logic [7:0] SFR_WDATA_I,  // wdata
	input wire logic [7:0] SFR_RDATA_O,  // rdata
	input wire logic       VBUS_I,       // power
	input wire logic       DP_PULLUP_O,  // D+ pull
	input wire logic       DM_PULLUP_O,  // D- pull
	input wire logic       FULL_SPEED_O, // speed
	input wire logic       XCVR_EN_O,    // enable
	input wire logic       TOK_VALID_I,  // token in
	input wire logic       TOK_READY_O,  // token ok
	input wire logic       PIPE_VALID_O, // pipe out
	input wire logic [2:0] PIPE_SEL_O,   // index
	input wire logic [9:0] PIPE_BASE_O   // base
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	// register address match, other addresses are refused
	wire logic at_reg = SFR_ADDR_I == 8'hD7;
	property p_dp; DP_PULLUP_O |-> FULL_SPEED_O; endproperty
	a_dp: assert property (p_dp) else $error("D+ pull at low speed");
	property p_dm; DM_PULLUP_O |-> !FULL_SPEED_O; endproperty
	a_dm: assert property (p_dm) else $error("D- pull at full speed");
	property p_vb; !VBUS_I [*3] |-> !DP_PULLUP_O && !DM_PULLUP_O; endproperty
	a_vb: assert property (p_vb) else $error("pull without power");
	property p_wr; SFR_WR_I && at_reg |=> XCVR_EN_O == $past(SFR_WDATA_I[6]) && FULL_SPEED_O == $past(SFR_WDATA_I[5]); endproperty
	a_wr: assert property (p_wr) else $error("write lost");
	property p_off; SFR_WR_I && at_reg && !SFR_WDATA_I[7] |=> !DP_PULLUP_O && !DM_PULLUP_O; endproperty
	a_off: assert property (p_off) else $error("pull while off");
	property p_unm; SFR_RD_I && !at_reg |=> SFR_RDATA_O == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	property p_hold; !SFR_RD_I |=> $stable(SFR_RDATA_O); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_dfr; SFR_RD_I && at_reg && !XCVR_EN_O |=> !SFR_RDATA_O[2]; endproperty
	a_dfr: assert property (p_dfr) else $error("diff bit while off");
	property p_tok; TOK_VALID_I && TOK_READY_O |=> PIPE_VALID_O; endproperty
	a_tok: assert property (p_tok) else $error("token lost");
	property p_base; PIPE_VALID_O |-> PIPE_BASE_O == {PIPE_SEL_O, 7'h00}; endproperty
	a_base: assert property (p_base) else $error("bad base");
	c_fs: cover property (DP_PULLUP_O);
	c_ls: cover property (DM_PULLUP_O);
	c_full: cover property (PIPE_VALID_O && !TOK_READY_O);
endmodule : usbft_checker
bind usbft_ctrl usbft_checker chk (.*);

// ### tb/usbft_host_model.sv
// host end of the cable: pull-downs, device drive wins
`timescale 1ns/10ps
module usbft_host_model (
	input  wire logic dp_i,      // device D+ value
	input  wire logic dp_oe_n_i, // device D+ enable
	input  wire logic dp_pu_i,   // D+ pull-up
	input  wire logic dm_i,      // device D- value
	input  wire logic dm_oe_n_i, // device D- enable
	input  wire logic dm_pu_i,   // D- pull-up
	output logic      dp_o,      // D+ level
	output logic      dm_o       // D- level
);
	// released line falls to the host pull-down unless pulled up
	assign dp_o = !dp_oe_n_i ? dp_i : dp_pu_i;
	assign dm_o = !dm_oe_n_i ? dm_i : dm_pu_i;
endmodule : usbft_host_model

// ### tb/usb_function_transceiver_ctrl_test.sv
// self-checking bench for the transceiver control block
`timescale 1ns/10ps
module usb_function_transceiver_ctrl_test;
	logic       clk, rst_n, wr, rd, vbus, tv, tin, pr, dp, dm, dpo, dpoe, dmo, dmoe, dppu, dmpu, fs, en, trdy, pv, hit;
	logic [7:0] addr, wd, rdata, ta;
	logic [2:0] sel;
	logic [9:0] base;
	int         failures = 0;
	int         checks_done = 0;
	usbft_ctrl dut (.CLK_I(clk), .RESETN_I(rst_n), .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_RD_I(rd),
		.SFR_WDATA_I(wd), .SFR_RDATA_O(rdata), .VBUS_I(vbus), .DP_I(dp), .DP_O(dpo), .DP_OE_N_O(dpoe),
		.DM_I(dm), .DM_O(dmo), .DM_OE_N_O(dmoe), .DP_PULLUP_O(dppu), .DM_PULLUP_O(dmpu), .FULL_SPEED_O(fs),
		.XCVR_EN_O(en), .TOK_VALID_I(tv), .TOK_READY_O(trdy), .TOK_ADDR_I(ta), .TOK_IN_I(tin),
		.PIPE_VALID_O(pv), .PIPE_READY_I(pr), .PIPE_HIT_O(hit), .PIPE_SEL_O(sel), .PIPE_BASE_O(base));
	usbft_host_model host (.dp_i(dpo), .dp_oe_n_i(dpoe), .dp_pu_i(dppu), .dm_i(dmo), .dm_oe_n_i(dmoe),
		.dm_pu_i(dmpu), .dp_o(dp), .dm_o(dm));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task wreg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		{addr, wd, wr} = {a, d, 1'b1};
		@(negedge clk);
		wr = 1'b0;
	endtask : wreg
	task rchk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		{addr, rd} = {a, 1'b1};
		@(negedge clk);
		rd = 1'b0;
		chk(rdata, exp);
	endtask : rchk
	// pull-up placement, power gating, line status, unmapped address
	task t_pullup;
		vbus = 1'b1;
		wreg(8'hD7, 8'hE7);
		repeat (3) @(negedge clk);
		chk({dppu, dmpu, fs, en}, 4'b1011);
		rchk(8'hD7, 8'hE6);
		wreg(8'hD7, 8'hC0);
		repeat (3) @(negedge clk);
		chk({dppu, dmpu, fs}, 3'b010);
		rchk(8'hD7, 8'hC1);
		vbus = 1'b0;
		repeat (3) @(negedge clk);
		chk({dppu, dmpu}, 2'b00);
		vbus = 1'b1;
		wreg(8'hD7, 8'h60);
		repeat (3) @(negedge clk);
		chk({dppu, dmpu, fs}, 3'b001);
		wreg(8'hD6, 8'hFF);
		rchk(8'hD6, 8'h00);
		rchk(8'hD7, 8'h60);
	endtask : t_pullup
	// every test mode forces the lines it names
	task automatic t_modes;
		logic [7:0] exp [4] = '{8'h40, 8'h4E, 8'h51, 8'h58};
		vbus = 1'b0;
		for (int m = 0; m < 4; m++) begin
			wreg(8'hD7, {3'b010, 2'(m), 3'b000});
			repeat (4) @(negedge clk);
			rchk(8'hD7, exp[m]);
		end
		wreg(8'hD7, 8'h00);
		repeat (3) @(negedge clk);
		chk({dpoe, dmoe}, 2'b11);
	endtask : t_modes
	task push(input logic [8:0] t);
		@(negedge clk);
		{tin, ta, tv} = {t, 1'b1};
		@(negedge clk);
		tv = 1'b0;
	endtask : push
	task pop(input logic [3:0] exp);
		@(negedge clk);
		chk({pv, hit, sel, base}, {1'b1, exp, exp[2:0], 7'h00});
		pr = 1'b1;
		@(negedge clk);
		pr = 1'b0;
	endtask : pop
	// buffer fills while consumer stalls, then endpoint zero, in-range and off-table addresses decode
	task automatic t_tokens;
		logic [8:0] tok [7] = '{9'h082, 9'h100, 9'h000, 9'h003, 9'h081, 9'h004, 9'h080};
		logic [3:0] res [7] = '{4'hD, 4'h9, 4'h8, 4'hE, 4'hB, 4'h0, 4'h0};
		push(9'h082);
		push(9'h001);
		chk(trdy, 1'b0);
		pop(4'hD);
		pop(4'hA);
		for (int i = 0; i < 7; i++) begin
			push(tok[i]);
			pop(res[i]);
		end
	endtask : t_tokens
	task end_of_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		{rst_n, wr, rd, vbus, tv, tin, pr, addr, wd, ta} = '0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		rchk(8'hD7, 8'h00);
		t_pullup;
		t_modes;
		t_tokens;
		end_of_test;
	end
	// run needs about 110 cycles, allow far more
	initial begin
		#100000;
		failures++;
		end_of_test;
	end
endmodule : usb_function_transceiver_ctrl_test
